// File: logic/mcbo_consts.vh
// Constants for the complement / BCD adjust execute slice.
// Assumes one core clock; register offsets are byte addresses on APB.
// Function
// - Watchdog clear resets the watchdog counter and clears the expired and sleep flags.
// - Invert memory writes the complement of the addressed byte back to it, touching only the zero flag.
// - Invert to accumulator loads the complement into the working register, memory untouched, zero flag only.
// - Bcd adjust adds 6 to the low nibble when it exceeds 9 or the half nibble overflow flag is set.
// - Bcd adjust adds 6 to the high nibble when it exceeds 9 or the carry flag is set.
// - The bcd correction is one of 00H, 06H, 60H or 66H added to the working register.
// - Bcd adjust changes only the carry flag, set when the high nibble exceeds 9 or the carry flag was already set.
// - The adjusted value goes to the addressed memory location, not the working register.
`ifndef MCBO_CONSTS_VH
`define MCBO_CONSTS_VH
`define MCBO_OFF_CTRL     12'h000
`define MCBO_OFF_ACC      12'h004
`define MCBO_OFF_MDATA    12'h008
`define MCBO_OFF_FLAGS    12'h00C
`define MCBO_OFF_RESULT   12'h010
`define MCBO_OFF_WDT      12'h014
`define MCBO_OP_WDTCLR    3'h1
`define MCBO_OP_INV       3'h2
`define MCBO_OP_INVA      3'h3
`define MCBO_OP_BCD       3'h4
`define MCBO_FLG_Z        0
`define MCBO_FLG_AC       1
`define MCBO_FLG_C        2
`define MCBO_FLG_TO       3
`define MCBO_FLG_PDF      4
`define MCBO_NIB_MAX      4'h9
`define MCBO_NIB_FIX      8'h06
`define MCBO_HI_FIX       8'h60
`define MCBO_WDT_W        16
`endif

// File: logic/mcbo_alu.v
// Combinational result of the four instructions of this slice.
// Assumes operands are stable; the caller registers everything.
`timescale 1ns/100ps
`default_nettype none
`include "mcbo_consts.vh"
module mcbo_alu
(
    input  wire [2:0] op,        // Selected instruction
    input  wire [7:0] acc,       // Working register value
    input  wire [7:0] mem,       // Addressed memory byte
    input  wire       ac_in,     // Half nibble overflow flag
    input  wire       c_in,      // Carry flag
    output reg  [7:0] result,    // 8-bit result
    output reg        c_out,     // Next carry
    output wire       zero       // Result equals zero
);
    wire       lo_fix;
    wire       hi_fix;
    wire [8:0] sum;
    assign lo_fix = (acc[3:0] > `MCBO_NIB_MAX) | ac_in;
    assign hi_fix = (acc[7:4] > `MCBO_NIB_MAX) | c_in;
    assign sum = {1'b0, acc} + {1'b0, (lo_fix ? `MCBO_NIB_FIX : 8'h00) | (hi_fix ? `MCBO_HI_FIX : 8'h00)};
    assign zero = (result == 8'h00);

    // Result mux; carry held except on adjust
    always @*
    begin
        result = 8'h00;
        c_out  = c_in;
        case (op)
            `MCBO_OP_INV,
            `MCBO_OP_INVA:
            begin
                result = ~mem;
            end
            `MCBO_OP_BCD:
            begin
                result = sum[7:0];
                c_out  = c_in | sum[8] | hi_fix;
            end
            default:
            begin
                result = 8'h00;
            end
        endcase
    end
endmodule // mcbo_alu
`default_nettype wire

// File: logic/mcbo_top.v
// APB-reached execute slice: watchdog clear, invert and bcd adjust.
// Assumes a single-wait-free APB master on pclk; memory is modelled by
// the operand register and the result/memory write strobe outputs.
`timescale 1ns/100ps
`default_nettype none
`include "mcbo_consts.vh"
module mcbo_top
(
    input  wire        pclk,      // Core clock, 200 MHz
    input  wire        presetn,   // Asynchronous reset, active low
    input  wire        clk_en,    // Freezes all state when low
    input  wire        psel,      // APB select
    input  wire        penable,   // APB access phase
    input  wire        pwrite,    // APB write
    input  wire [11:0] paddr,     // APB byte address
    input  wire [31:0] pwdata,    // APB write data
    output reg  [31:0] prdata,    // APB read data
    output reg         pready,    // APB ready
    output reg         pslverr,   // APB error on unmapped address
    output reg         mem_we,    // Memory write pulse
    output reg  [7:0]  mem_wdata  // Memory write data
);
    reg  [7:0]  acc_reg;
    reg  [7:0]  mdata_reg;
    reg  [4:0]  flags_reg;
    reg  [7:0]  result_reg;
    reg  [15:0] wdt_reg;
    wire [7:0]  alu_res;
    wire        alu_c;
    wire        alu_z;
    wire        acc_w;
    wire        wr;
    wire        rd;
    wire        mapped;
    wire        exec;
    wire [2:0]  op;

    assign wr     = psel & penable & pwrite & ~pready;
    assign rd     = psel & penable & ~pwrite & ~pready;
    assign mapped = (paddr == `MCBO_OFF_CTRL) | (paddr == `MCBO_OFF_ACC) | (paddr == `MCBO_OFF_MDATA) |
                    (paddr == `MCBO_OFF_FLAGS) | (paddr == `MCBO_OFF_RESULT) | (paddr == `MCBO_OFF_WDT);
    assign exec   = wr & (paddr == `MCBO_OFF_CTRL);
    assign op     = pwdata[2:0];
    assign acc_w  = wr & (paddr == `MCBO_OFF_ACC);

    mcbo_alu u_alu
    (
        .op     (op),
        .acc    (acc_reg),
        .mem    (mdata_reg),
        .ac_in  (flags_reg[`MCBO_FLG_AC]),
        .c_in   (flags_reg[`MCBO_FLG_C]),
        .result (alu_res),
        .c_out  (alu_c),
        .zero   (alu_z)
    );

    // APB handshake: one wait state, answer in the access phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else if (clk_en)
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (rd)
            begin
                case (paddr)
                    `MCBO_OFF_ACC:    prdata <= {24'h000000, acc_reg};
                    `MCBO_OFF_MDATA:  prdata <= {24'h000000, mdata_reg};
                    `MCBO_OFF_FLAGS:  prdata <= {27'h0, flags_reg};
                    `MCBO_OFF_RESULT: prdata <= {24'h000000, result_reg};
                    `MCBO_OFF_WDT:    prdata <= {16'h0000, wdt_reg};
                    default:          prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Datapath state; the watchdog counter free-runs so clears are visible
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_reg    <= 8'h00;
            mdata_reg  <= 8'h00;
            flags_reg  <= 5'h00;
            result_reg <= 8'h00;
            wdt_reg    <= 16'h0000;
            mem_we     <= 1'b0;
            mem_wdata  <= 8'h00;
        end
        else if (clk_en)
        begin
            mem_we  <= 1'b0;
            wdt_reg <= wdt_reg + 16'h0001;
            if (acc_w)
                acc_reg <= pwdata[7:0];
            if (wr & (paddr == `MCBO_OFF_MDATA))
                mdata_reg <= pwdata[7:0];
            if (wr & (paddr == `MCBO_OFF_FLAGS))
                flags_reg <= pwdata[4:0];
            if (exec)
            begin
                case (op)
                    `MCBO_OP_WDTCLR:
                    begin
                        wdt_reg                <= 16'h0000;
                        flags_reg[`MCBO_FLG_TO]  <= 1'b0;
                        flags_reg[`MCBO_FLG_PDF] <= 1'b0;
                    end
                    `MCBO_OP_INV:
                    begin
                        mdata_reg  <= alu_res;
                        mem_wdata  <= alu_res;
                        mem_we     <= 1'b1;
                        result_reg <= alu_res;
                        flags_reg[`MCBO_FLG_Z] <= alu_z;
                    end
                    `MCBO_OP_INVA:
                    begin
                        acc_reg    <= alu_res;
                        result_reg <= alu_res;
                        flags_reg[`MCBO_FLG_Z] <= alu_z;
                    end
                    `MCBO_OP_BCD:
                    begin
                        mdata_reg  <= alu_res;
                        mem_wdata  <= alu_res;
                        mem_we     <= 1'b1;
                        result_reg <= alu_res;
                        flags_reg[`MCBO_FLG_C] <= alu_c;
                    end
                    default:
                    begin
                        result_reg <= result_reg;
                    end
                endcase
            end
        end
    end
endmodule // mcbo_top
`default_nettype wire

// File: test/mcbo_properties.sv
// Checker for the execute slice, bound to mcbo_top.
// Assumes one clock and an APB master that holds each request.
`timescale 1ns/100ps
`default_nettype none
`include "mcbo_consts.vh"
module mcbo_properties
(
    input wire logic        pclk,      // Clock
    input wire logic        presetn,   // Reset
    input wire logic        clk_en,    // Run
    input wire logic        psel,      // Select
    input wire logic        penable,   // Access
    input wire logic        pwrite,    // Write
    input wire logic [11:0] paddr,     // Address
    input wire logic [31:0] pwdata,    // Write data
    input wire logic [31:0] prdata,    // Read data
    input wire logic        pready,    // Ready
    input wire logic        pslverr,   // Error
    input wire logic        mem_we,    // Memory write
    input wire logic [7:0]  mem_wdata  // Memory byte
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // First access cycle, and control writes among them
    wire       tk = psel & penable & !pready & clk_en;
    wire       cx = tk & pwrite & (paddr == `MCBO_OFF_CTRL);
    wire [2:0] op = pwdata[2:0];
    logic [7:0] md, ac;
    // Shadows, so results can be tied to their operands
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            md <= 8'h00;
            ac <= 8'h00;
        end
        else
        begin
            if (tk & pwrite & (paddr == `MCBO_OFF_MDATA)) md <= pwdata[7:0];
            if (mem_we) md <= mem_wdata;
            if (tk & pwrite & (paddr == `MCBO_OFF_ACC)) ac <= pwdata[7:0];
            if (cx & (op == `MCBO_OP_INVA)) ac <= ~md;
        end
    property p_ans; tk |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer after access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_inv; cx && op == `MCBO_OP_INV |=> mem_we && mem_wdata == ~$past(md); endproperty
    a_inv: assert property (p_inv) else $error("bad invert write");
    property p_inva; cx && op == `MCBO_OP_INVA |=> !mem_we; endproperty
    a_inva: assert property (p_inva) else $error("memory written");
    property p_wdt; cx && op == `MCBO_OP_WDTCLR |=> !mem_we && !pslverr; endproperty
    a_wdt: assert property (p_wdt) else $error("bad watchdog clear");
    property p_bcd; cx && op == `MCBO_OP_BCD |=> mem_we && (mem_wdata - $past(ac)) inside {8'h00, 8'h06, 8'h60, 8'h66};
    endproperty
    a_bcd: assert property (p_bcd) else $error("bad adjust step");
    property p_lo; cx && op == `MCBO_OP_BCD && ac[3:0] > 4'h9 |=> (mem_wdata - $past(ac)) inside {8'h06, 8'h66};
    endproperty
    a_lo: assert property (p_lo) else $error("low nibble not fixed");
    property p_hi; cx && op == `MCBO_OP_BCD && ac[7:4] > 4'h9 |=> (mem_wdata - $past(ac)) inside {8'h60, 8'h66};
    endproperty
    a_hi: assert property (p_hi) else $error("high nibble not fixed");
endmodule // mcbo_properties
bind mcbo_top mcbo_properties u_props (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_we, .mem_wdata);
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for mcbo_top over APB.
// Assumes the slice answers each access with one wait state.
`timescale 1ns/100ps
`default_nettype none
`include "mcbo_consts.vh"
module testbench;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, mem_we, c;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v0;
    logic [7:0]  mem_wdata, a, b, x, fx, r;
    logic [4:0]  f;
    logic [32:0] rq[$];
    logic [7:0]  mq[$];
    int          err_total = 0, n_checks = 0, cyc = 0;
    mcbo_top uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mem_we, .mem_wdata);
    always #2.5 pclk = ~pclk;
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One APB transfer; an idle cycle after it keeps psel edges apart
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1, ad, d);
    endtask
    task automatic rdx(input logic [11:0] ad, input logic [32:0] exp);
        rq.push_back(exp);
        apb(0, ad, 0);
    endtask
    // Oldest note against each finished read and memory write; hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            err_total++;
            report_and_stop;
        end
        if (psel && penable && pready && !pwrite && rq.size() > 0)
            chk({pslverr, prdata}, rq.pop_front());
        if (mem_we === 1'b1)
            chk(mem_wdata, mq.pop_front());
    end
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 0;
        clk_en = 1;
        r = $urandom(92);
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 12; i++)
        begin
            a = (i == 0) ? 8'hFF : $urandom;
            x = (i == 1) ? 8'h99 : $urandom;
            f = $urandom;
            b = ~a;
            // Invert in place, then into the working register
            wr(`MCBO_OFF_MDATA, a);
            wr(`MCBO_OFF_FLAGS, f);
            mq.push_back(b);
            wr(`MCBO_OFF_CTRL, `MCBO_OP_INV);
            rdx(`MCBO_OFF_MDATA, b);
            rdx(`MCBO_OFF_FLAGS, {f[4:1], b == 8'h00});
            wr(`MCBO_OFF_MDATA, a);
            wr(`MCBO_OFF_FLAGS, f);
            wr(`MCBO_OFF_CTRL, `MCBO_OP_INVA);
            rdx(`MCBO_OFF_ACC, b);
            rdx(`MCBO_OFF_MDATA, a);
            rdx(`MCBO_OFF_FLAGS, {f[4:1], b == 8'h00});
            // Decimal adjust from the original nibbles and flags
            fx = ((x[3:0] > 4'h9 || f[1]) ? 8'h06 : 8'h00) | ((x[7:4] > 4'h9 || f[2]) ? 8'h60 : 8'h00);
            {c, r} = x + fx;
            mq.push_back(r);
            wr(`MCBO_OFF_ACC, x);
            wr(`MCBO_OFF_FLAGS, f);
            wr(`MCBO_OFF_CTRL, `MCBO_OP_BCD);
            rdx(`MCBO_OFF_MDATA, r);
            rdx(`MCBO_OFF_RESULT, r);
            rdx(`MCBO_OFF_ACC, x);
            rdx(`MCBO_OFF_FLAGS, {f[4:3], c | f[2] | fx[6], f[1:0]});
        end
        // Watchdog clear after the counter has run a while
        wr(`MCBO_OFF_FLAGS, 32'h18);
        apb(0, `MCBO_OFF_WDT, 0);
        chk(rd > 32'h20, 33'h1);
        wr(`MCBO_OFF_CTRL, `MCBO_OP_WDTCLR);
        rdx(`MCBO_OFF_FLAGS, 33'h0);
        apb(0, `MCBO_OFF_WDT, 0);
        chk(rd < 32'h10, 33'h1);
        // Frozen clock enable must stop the counter
        v0 = rd;
        clk_en <= 0;
        repeat (40) @(posedge pclk);
        clk_en <= 1;
        apb(0, `MCBO_OFF_WDT, 0);
        chk(rd - v0 < 32'h10, 33'h1);
        // Unmapped place and write-only control
        rdx(12'h018, {1'b1, 32'h0});
        rdx(`MCBO_OFF_CTRL, 33'h0);
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
